// ---- tbr_top.v ----
// Summary of operation
// - trace data is a 16-bit port valid only for aligned word reads
// - byte or misaligned trace reads return zero and keep the read pointer
// - while armed, trace word reads return zero and keep the pointer
// - trace storage has no reset value and is not initialised
// - full flag at bit 7 sets after 64 words stored since arming
// - with full set, all 64 entries count as valid
// - writing one to arm clears the full flag
// - six-bit count in bits 5:0 counts valid words from zero
// - count wrap from all ones to zero sets the full flag
// - writing one to arm clears count and full flag
// - begin mode at 64 words clears arm, breaks if enabled
// - start select one: trigger starts storing; zero: trigger ends storing
// - arm decides whether capture words are stored
// - break enable requests a breakpoint when a session completes
//
// Purpose: trace buffer capture, readout and count over AXI4-Lite
// Assumes: capture_valid/trig_in come from the comparator logic, synchronous to clk
// Notes: one write and one read outstanding at a time
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tbr_defines.vh"

module tbr_top #(
  parameter DATA_W = 16,
  parameter ADDR_W = 6
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // capture side
  input wire capture_valid,
  input wire [DATA_W-1:0] capture_data,
  input wire trig_in,
  // debug outputs
  output reg armed,
  output reg break_req,
  output reg irq
);

  // ****************************************
  // declarations
  // ****************************************
  reg [7:0] awaddr_q;
  reg aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_held_q;
  reg arm_q;
  reg begin_q;
  reg brk_en_q;
  reg [1:0] cap_mode_q;
  reg started_q;
  reg [ADDR_W-1:0] rd_ptr_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  wire [ADDR_W-1:0] cnt;
  wire full;
  wire wrap;
  wire [DATA_W-1:0] rd_data;
  wire wr_fire;
  wire ctl_wr;
  wire sw_arm;
  wire sw_disarm;
  wire store;
  wire begin_done;
  wire end_done;
  wire hw_done;
  wire ar_fire;
  wire trace_word_rd;
  wire cnt_inc;
  reg [31:0] rdata_d;
  reg [1:0] rresp_d;
  reg [1:0] bresp_d;

  // ****************************************
  // write channel capture
  // ****************************************
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      awaddr_q <= 8'h00;
      aw_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_held_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TBR_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_held_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_held_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= bresp_d;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @* begin
    case (awaddr_q)
      `TBR_ADDR_CONTROL, `TBR_ADDR_IRQ_STATUS, `TBR_ADDR_IRQ_MASK,
      `TBR_ADDR_DATA_HIGH, `TBR_ADDR_DATA_LOW, `TBR_ADDR_WORD_COUNT: begin
        bresp_d = `TBR_RESP_OKAY;
      end
      default: begin
        bresp_d = `TBR_RESP_SLVERR;
      end
    endcase
  end

  // ****************************************
  // control register and session sequencing
  // ****************************************
  assign ctl_wr = wr_fire && (awaddr_q == `TBR_ADDR_CONTROL) && wstrb_q[0];
  assign sw_arm = ctl_wr && wdata_q[`TBR_CTL_ARM];
  assign sw_disarm = ctl_wr && !wdata_q[`TBR_CTL_ARM];
  // begin mode stores from the trigger cycle on, end mode stores until it
  assign store = arm_q && capture_valid && (begin_q ? (started_q || trig_in) : 1'b1);
  assign begin_done = arm_q && begin_q && wrap;
  // the capture on the trigger cycle is still kept in end mode
  assign end_done = arm_q && !begin_q && trig_in;
  assign hw_done = (begin_done || end_done) && !sw_arm;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_q <= 1'b0;
      begin_q <= 1'b0;
      brk_en_q <= 1'b0;
      cap_mode_q <= 2'h0;
      started_q <= 1'b0;
      armed <= 1'b0;
      break_req <= 1'b0;
    end else begin
      break_req <= 1'b0;
      if (ctl_wr) begin
        begin_q <= wdata_q[`TBR_CTL_BEGIN];
        brk_en_q <= wdata_q[`TBR_CTL_BRK];
        cap_mode_q <= wdata_q[1:0];
      end
      if (sw_arm) begin
        arm_q <= 1'b1;
        started_q <= 1'b0;
      end else if (sw_disarm) begin
        arm_q <= 1'b0;
      end else if (hw_done) begin
        arm_q <= 1'b0;
        break_req <= brk_en_q;
      end else if (arm_q && begin_q && trig_in) begin
        started_q <= 1'b1;
      end
      armed <= sw_arm ? 1'b1 : ((sw_disarm || hw_done) ? 1'b0 : arm_q);
    end
  end

  tbr_counter #(
    .CNT_W(ADDR_W)
  ) u_counter (
    .clk(clk),
    .rst_b(rst_b),
    .clr(sw_arm),
    .inc(store && !sw_arm),
    .cnt(cnt),
    .full(full),
    .wrap(wrap)
  );

  // the count is the ring write address, so end mode overwrites oldest
  tbr_ram #(
    .DATA_W(DATA_W),
    .ADDR_W(ADDR_W)
  ) u_ram (
    .clk(clk),
    .wr_en(store && !sw_arm),
    .wr_addr(cnt),
    .wr_data(capture_data),
    .rd_addr(rd_ptr_q),
    .rd_data(rd_data)
  );

  // ****************************************
  // read pointer
  // ****************************************
  assign cnt_inc = store && !sw_arm;
  assign ar_fire = s_axi_arvalid && s_axi_arready;
  // only an aligned word read of the high index while disarmed counts
  assign trace_word_rd = ar_fire && (s_axi_araddr == `TBR_ADDR_DATA_HIGH) && !arm_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ptr_q <= {ADDR_W{1'b0}};
    end else if (sw_arm) begin
      rd_ptr_q <= {ADDR_W{1'b0}};
    end else if (sw_disarm || hw_done) begin
      // after a wrap the oldest surviving entry is the next write address, so a word
      // stored in this very cycle moves it on by one
      rd_ptr_q <= (full || wrap) ? (cnt + {{(ADDR_W-1){1'b0}}, cnt_inc}) : {ADDR_W{1'b0}};
    end else if (trace_word_rd) begin
      rd_ptr_q <= rd_ptr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  always @* begin
    rdata_d = 32'h0000_0000;
    rresp_d = `TBR_RESP_OKAY;
    case ({s_axi_araddr[7:2], 2'b00})
      `TBR_ADDR_CONTROL: begin
        rdata_d = {24'h00_0000, 1'b0, arm_q, 1'b0, begin_q, brk_en_q, 1'b0, cap_mode_q};
      end
      `TBR_ADDR_IRQ_STATUS: begin
        rdata_d = {30'h0000_0000, irq_stat_q};
      end
      `TBR_ADDR_IRQ_MASK: begin
        rdata_d = {30'h0000_0000, irq_mask_q};
      end
      `TBR_ADDR_DATA_HIGH: begin
        // zero for misaligned or armed access
        if (trace_word_rd) begin
          rdata_d = {{(32-DATA_W){1'b0}}, rd_data};
        end
      end
      `TBR_ADDR_DATA_LOW: begin
        rdata_d = 32'h0000_0000; // a lone byte half is never a word read
      end
      `TBR_ADDR_WORD_COUNT: begin
        if (s_axi_araddr[1:0] == 2'b00) begin
          rdata_d = {24'h00_0000, full, 1'b0, cnt};
        end
      end
      default: begin
        rresp_d = `TBR_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `TBR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_d;
        s_axi_rresp <= rresp_d;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // interrupts
  // ****************************************
  // set wins over a write-one clear in the same cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_stat_q <= `TBR_IRQ_RESET;
      irq_mask_q <= `TBR_IRQ_RESET;
      irq <= 1'b0;
    end else begin
      if (wr_fire && (awaddr_q == `TBR_ADDR_IRQ_STATUS) && wstrb_q[0]) begin
        irq_stat_q <= (irq_stat_q & ~wdata_q[1:0]) | {hw_done, store && !sw_arm && wrap};
      end else begin
        irq_stat_q <= irq_stat_q | {hw_done, store && !sw_arm && wrap};
      end
      if (wr_fire && (awaddr_q == `TBR_ADDR_IRQ_MASK) && wstrb_q[0]) begin
        irq_mask_q <= wdata_q[1:0];
      end
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule // tbr_top

// ---- tbr_defines.vh ----
// Purpose: shared constants of the trace buffer readout block
// Assumes: included by its bare name from every design file of the block
// Notes: byte address of a trace register is four times its index
`ifndef TBR_DEFINES_VH
`define TBR_DEFINES_VH

// ****************************************
// register indices and byte addresses
// ****************************************
`define TBR_IDX_DATA_HIGH 8'h22
`define TBR_IDX_DATA_LOW 8'h23
`define TBR_IDX_WORD_COUNT 8'h24
`define TBR_ADDR_DATA_HIGH 8'h88
`define TBR_ADDR_DATA_LOW 8'h8C
`define TBR_ADDR_WORD_COUNT 8'h90
`define TBR_ADDR_CONTROL 8'h00
`define TBR_ADDR_IRQ_STATUS 8'h04
`define TBR_ADDR_IRQ_MASK 8'h08

// ****************************************
// field positions
// ****************************************
`define TBR_CTL_ARM 6
`define TBR_CTL_BEGIN 4
`define TBR_CTL_BRK 3
`define TBR_CNT_FULL 7
`define TBR_IRQ_FULL 0
`define TBR_IRQ_DONE 1

// ****************************************
// reset values and encodings
// ****************************************
`define TBR_CTL_RESET 8'h00
`define TBR_IRQ_RESET 2'h0
`define TBR_CNT_RESET 6'h00
`define TBR_RESP_OKAY 2'h0
`define TBR_RESP_SLVERR 2'h2

`endif

// ---- tbr_ram.v ----
// Purpose: trace word storage, one write port, one asynchronous read port
// Assumes: writer and reader addresses are stable around the clock edge
// Notes: storage has no reset; contents are undefined until written
`timescale 1ns/1ps
`include "tbr_defines.vh"

module tbr_ram #(
  parameter DATA_W = 16,
  parameter ADDR_W = 6
) (
  // clock
  input wire clk,
  // write side
  input wire wr_en,
  input wire [ADDR_W-1:0] wr_addr,
  input wire [DATA_W-1:0] wr_data,
  // read side
  input wire [ADDR_W-1:0] rd_addr,
  output wire [DATA_W-1:0] rd_data
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // no reset on purpose, readback just mirrors the array
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule // tbr_ram

// ---- tbr_counter.v ----
// Purpose: valid word count and buffer full flag
// Assumes: clr and inc come from the control logic of the top
// Notes: the count doubles as the ring write address
`timescale 1ns/1ps
`include "tbr_defines.vh"

module tbr_counter #(
  parameter CNT_W = 6
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // control
  input wire clr,
  input wire inc,
  // state
  output wire [CNT_W-1:0] cnt,
  output wire full,
  output wire wrap
);

  reg [CNT_W-1:0] cnt_q;
  reg full_q;

  assign wrap = inc && (&cnt_q);
  assign cnt = cnt_q;
  assign full = full_q;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= `TBR_CNT_RESET;
      full_q <= 1'b0;
    end else if (clr) begin
      // arming clears count and flag together
      cnt_q <= `TBR_CNT_RESET;
      full_q <= 1'b0;
    end else if (inc) begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      if (wrap) begin
        full_q <= 1'b1;
      end
    end
  end

endmodule // tbr_counter

// ---- tbr_chk.sv ----
// Purpose: port-level checks of the trace buffer readout block
// Assumes: one clock domain, rst_b asynchronous and active low
// Notes: bound to every tbr_top instance
`timescale 1ns/1ps

module tbr_chk (
  // clock and reset
  input logic clk,
  input logic rst_b,
  // bus
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // debug outputs
  input logic armed,
  input logic break_req,
  input logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_b_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_b_busy: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_r_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  chk_brk_disarm: assert property (
    break_req |-> !armed)
    else $error("break while still armed");
  chk_brk_pulse: assert property (
    break_req |=> !break_req)
    else $error("break request longer than one cycle");

  cover property (break_req);
  cover property (irq);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // tbr_chk

bind tbr_top tbr_chk tbr_chk_inst (
  .clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .armed(armed),
  .break_req(break_req), .irq(irq)
);

// ---- tbr_tb.sv ----
// Purpose: self-checking bench of the trace buffer readout block
// Assumes: bus tasks start and end just after a rising edge
// Notes: every wait is bounded at 40 cycles
`timescale 1ns/1ps
`include "tbr_defines.vh"

module tb;
  localparam logic [7:0] a_ctl = `TBR_ADDR_CONTROL;
  localparam logic [7:0] a_sts = `TBR_ADDR_IRQ_STATUS;
  localparam logic [7:0] a_msk = `TBR_ADDR_IRQ_MASK;
  localparam logic [7:0] a_hi = `TBR_ADDR_DATA_HIGH;
  localparam logic [7:0] a_lo = `TBR_ADDR_DATA_LOW;
  localparam logic [7:0] a_cnt = `TBR_ADDR_WORD_COUNT;
  localparam logic [1:0] ok = `TBR_RESP_OKAY;
  localparam logic [1:0] se = `TBR_RESP_SLVERR;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic cv = 1'b0;
  logic trg = 1'b0;
  logic [15:0] cd = 16'h0;
  logic awr, wrd, brv, arr, rv, armed, brk, irq;
  logic [1:0] br, rr;
  logic [31:0] rdat;
  int fail_count = 0;
  int check_count = 0;
  int brk_n = 0;

  tbr_top tbr_top_inst (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(brv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .capture_valid(cv), .capture_data(cd),
    .trig_in(trg), .armed(armed), .break_req(brk), .irq(irq)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (brk === 1'b1) brk_n++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic hang(input int n);
    if (n >= 40) begin
      fail_count++;
      $display("ERROR at %0t: bus answer missing", $time);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end while (brv !== 1'b1 && n < 40);
    bry <= 1'b0;
    hang(n);
    chk({30'h0, br}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 40);
    rry <= 1'b0;
    hang(n);
    chk(rdat, exp);
    chk({30'h0, rr}, {30'h0, er});
  endtask

  // trigger only ever rides on the first word offered
  task automatic cap(input int cnt, input logic [15:0] base, input logic tg);
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk);
      cv <= 1'b1;
      cd <= base + i[15:0];
      trg <= tg && (i == 0);
    end
    @(posedge clk);
    cv <= 1'b0;
    trg <= 1'b0;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(a_cnt, 32'h0, ok);
    rd(a_ctl, 32'h0, ok);
    rd(8'h40, 32'h0, se);
    wr(8'h40, 32'h1, se);
    // end-trigger session, interrupts masked
    wr(a_ctl, 32'h40, ok);
    cap(66, 16'hB000, 1'b0);
    rd(a_cnt, 32'h82, ok);
    rd(a_hi, 32'h0, ok);
    chk({31'h0, irq}, 32'h0);
    rd(a_sts, 32'h1, ok);
    cap(1, 16'hB042, 1'b1);
    repeat (2) @(posedge clk);
    chk({31'h0, armed}, 32'h0);
    rd(a_cnt, 32'h83, ok);
    rd(a_hi, 32'hB003, ok);
    rd(a_lo, 32'h0, ok);
    rd(8'h89, 32'h0, ok);
    rd(a_hi, 32'hB004, ok);
    chk(brk_n, 32'h0);
    wr(a_sts, 32'h3, ok);
    rd(a_sts, 32'h0, ok);
    // begin-trigger session with break and interrupts enabled
    wr(a_msk, 32'h3, ok);
    wr(a_ctl, 32'h58, ok);
    rd(a_cnt, 32'h0, ok);
    cap(3, 16'hD000, 1'b0);
    rd(a_cnt, 32'h0, ok);
    cap(64, 16'hC000, 1'b1);
    repeat (3) @(posedge clk);
    chk({31'h0, armed}, 32'h0);
    chk(brk_n, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(a_cnt, 32'h80, ok);
    // capture mode left as recorded before the trace is read back
    rd(a_ctl, 32'h18, ok);
    rd(a_sts, 32'h3, ok);
    rd(a_hi, 32'hC000, ok);
    wr(a_sts, 32'h3, ok);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    give_verdict();
  end
endmodule // tb
